// ===== rtl/css_supervisor.sv
// Purpose: charge session supervisor with AXI4-Lite registers
// Assumes: packet decoder posts packets through REG_PKT or pkt port
// Notes: long counts are parameters so simulation can shorten them
//
// Summary of operation
// - low shutdown sense stops transfer, flags fault
// - shutdown ends after five minutes or removal
// - 4 kHz tone burst 400 ms at start
// - start pulse high 400 ms at start
// - reset pin low holds device reset
// - power-on reset sequences startup internally
// - charge-complete EPT: solid green, halt 5 s
// - full charge status: green, keep transferring
// - status below 90% returns charging indication
// - supervisor strap loads its firmware once
// - standby issues sleep; supervisor pulls reset
// - wake every 400 ms to ping
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module css_supervisor #(
    parameter longint unsigned SHDN_CYC = css_pkg::SHDN_CYC,
    parameter longint unsigned EPT_CYC = css_pkg::EPT_CYC,
    parameter longint unsigned WAKE_CYC = css_pkg::WAKE_CYC,
    parameter longint unsigned BURST_CYC = css_pkg::TONE_CYC,
    parameter longint unsigned HALF_CYC = css_pkg::TONE_HALF_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_done,
    input wire logic shdn_below,
    input wire logic rx_present,
    input wire logic sup_strap,
    input wire logic pkt_valid,
    input wire logic [1:0] pkt_kind,
    input wire logic [7:0] pkt_value,
    output logic power_on,
    output logic tone_out,
    output logic start_out,
    output logic [1:0] indication,
    output logic sleep_cmd,
    output logic fw_load,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    css_pkg::css_state_t state_reg;
    css_pkg::css_ind_t ind_reg;
    logic [39:0] tmr_reg;
    logic [31:0] ctrl_reg;
    logic [css_pkg::IRQ_W-1:0] ists_reg;
    logic [css_pkg::IRQ_W-1:0] ien_reg;
    logic [css_pkg::IRQ_W-1:0] iev;
    logic boot_reg;
    logic fw_reg;
    logic sleep_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic aw_have, w_have;
    logic bvalid_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [1:0] bresp_reg;
    logic [1:0] p_kind;
    logic [7:0] p_val;
    logic sw_pkt, p_valid, ept_done, cs_full, cs_low, go_xfer, wr_fire;
    logic wstrb0_reg;

    css_cue_if cue ();

    // ==========================================
    // Cue generator
    css_cue_gen #(
        .BURST_CYC(BURST_CYC),
        .HALF_CYC(HALF_CYC)
    ) u_cue (
        .clk(clk),
        .rst_n(rst_n),
        .cue(cue)
    );

    // ==========================================
    // Packet source: port or software write
    assign wr_fire = aw_have && w_have && !bvalid_reg;
    assign sw_pkt = wr_fire && (awaddr_reg == css_pkg::REG_PKT);
    assign p_valid = pkt_valid || sw_pkt;
    assign p_kind = pkt_valid ? pkt_kind : wdata_reg[9:8];
    assign p_val = pkt_valid ? pkt_value : wdata_reg[7:0];
    assign ept_done = p_valid && p_kind == css_pkg::PKT_EPT && p_val == css_pkg::EPT_CODE_DONE;
    assign cs_full = p_valid && p_kind == css_pkg::PKT_CS && p_val >= css_pkg::CS_FULL;
    assign cs_low = p_valid && p_kind == css_pkg::PKT_CS && p_val < css_pkg::CS_LOW;
    // Enter transfer only when a receiver sits on the pad
    assign go_xfer = (state_reg == css_pkg::CSS_IDLE) && rx_present && boot_reg && !shdn_below;
    assign cue.start = go_xfer;

    // ==========================================
    // Boot and supervisor strap, caught after reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_reg <= 1'b0;
            fw_reg <= 1'b0;
        end else if (!boot_reg && por_done) begin
            boot_reg <= 1'b1;
            fw_reg <= sup_strap;
        end else begin
            fw_reg <= 1'b0;
        end
    end

    // ==========================================
    // Session state machine; shutdown sense wins over all
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= css_pkg::CSS_IDLE;
            tmr_reg <= 40'h0;
            sleep_reg <= 1'b0;
        end else begin
            sleep_reg <= 1'b0;
            if (shdn_below && state_reg != css_pkg::CSS_SHDN) begin
                state_reg <= css_pkg::CSS_SHDN;
                tmr_reg <= 40'(SHDN_CYC - 1);
            end else begin
                case (state_reg)
                    css_pkg::CSS_IDLE: begin
                        if (go_xfer) begin
                            state_reg <= css_pkg::CSS_XFER;
                        end else if (boot_reg && ctrl_reg[0]) begin
                            state_reg <= css_pkg::CSS_SLEEP;
                            sleep_reg <= 1'b1;
                            tmr_reg <= 40'(WAKE_CYC - 1);
                        end
                    end
                    css_pkg::CSS_XFER: begin
                        if (ept_done) begin
                            state_reg <= css_pkg::CSS_HOLD;
                            tmr_reg <= 40'(EPT_CYC - 1);
                        end else if (!rx_present) begin
                            state_reg <= css_pkg::CSS_IDLE;
                        end
                    end
                    css_pkg::CSS_HOLD: begin
                        if (tmr_reg == 40'h0) begin
                            state_reg <= css_pkg::CSS_IDLE;
                        end else begin
                            tmr_reg <= tmr_reg - 40'h1;
                        end
                    end
                    css_pkg::CSS_SHDN: begin
                        if (!shdn_below && (tmr_reg == 40'h0 || !rx_present)) begin
                            state_reg <= css_pkg::CSS_IDLE;
                        end else if (tmr_reg != 40'h0) begin
                            tmr_reg <= tmr_reg - 40'h1;
                        end
                    end
                    css_pkg::CSS_SLEEP: begin
                        // Wake to ping; period must not exceed detection limit
                        if (tmr_reg == 40'h0) begin
                            state_reg <= css_pkg::CSS_IDLE;
                        end else begin
                            tmr_reg <= tmr_reg - 40'h1;
                        end
                    end
                    default: state_reg <= css_pkg::CSS_IDLE;
                endcase
            end
        end
    end

    // ==========================================
    // Indication: done, trickle and fault
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ind_reg <= css_pkg::CSS_IND_OFF;
        end else if (shdn_below) begin
            ind_reg <= css_pkg::CSS_IND_FAULT;
        end else if (state_reg == css_pkg::CSS_XFER && ept_done) begin
            ind_reg <= css_pkg::CSS_IND_DONE;
        end else if (state_reg == css_pkg::CSS_XFER && cs_full) begin
            ind_reg <= css_pkg::CSS_IND_DONE;
        end else if (state_reg == css_pkg::CSS_XFER && cs_low) begin
            ind_reg <= css_pkg::CSS_IND_CHG;
        end else if (go_xfer) begin
            ind_reg <= css_pkg::CSS_IND_CHG;
        end else if (state_reg == css_pkg::CSS_IDLE && !rx_present) begin
            ind_reg <= css_pkg::CSS_IND_OFF;
        end
    end

    assign power_on = (state_reg == css_pkg::CSS_XFER);
    assign indication = ind_reg;
    assign tone_out = cue.tone;
    assign start_out = cue.pulse;
    assign sleep_cmd = sleep_reg;
    assign fw_load = fw_reg;

    // ==========================================
    // Interrupts; set beats clear in the same cycle
    assign iev = {cs_full && state_reg == css_pkg::CSS_XFER,
                  ept_done && state_reg == css_pkg::CSS_XFER,
                  go_xfer,
                  shdn_below && state_reg != css_pkg::CSS_SHDN};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ists_reg <= '0;
        end else if (wr_fire && awaddr_reg == css_pkg::REG_IRQ_CLR) begin
            ists_reg <= (ists_reg & ~wdata_reg[css_pkg::IRQ_W-1:0]) | iev;
        end else begin
            ists_reg <= ists_reg | iev;
        end
    end
    assign irq = |(ists_reg & ien_reg);

    // ==========================================
    // AXI4-Lite write channel; address and data in either order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            awaddr_reg <= 8'h0;
            wdata_reg <= 32'h0;
            wstrb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0]; // Master may drop the strobe once W is taken
            end
            if (wr_fire) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= (awaddr_reg == css_pkg::REG_CTRL || awaddr_reg == css_pkg::REG_IRQ_EN
                    || awaddr_reg == css_pkg::REG_IRQ_CLR || awaddr_reg == css_pkg::REG_PKT)
                    ? 2'b00 : 2'b10;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_have && !bvalid_reg;
    assign s_axi_wready = !w_have && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // Writable registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= css_pkg::CTRL_RST;
            ien_reg <= '0;
        end else if (wr_fire && awaddr_reg == css_pkg::REG_CTRL && wstrb0_reg) begin
            ctrl_reg <= {31'h0, wdata_reg[0]};
        end else if (wr_fire && awaddr_reg == css_pkg::REG_IRQ_EN) begin
            ien_reg <= wdata_reg[css_pkg::IRQ_W-1:0];
        end
    end

    // ==========================================
    // AXI4-Lite read channel, one cycle answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= 2'b00;
            case (s_axi_araddr)
                css_pkg::REG_CTRL: rdata_reg <= ctrl_reg;
                css_pkg::REG_STAT: rdata_reg <= {24'h0, fw_reg, boot_reg, ind_reg,
                    cue.busy, state_reg};
                css_pkg::REG_IRQ_STAT: rdata_reg <= {28'h0, ists_reg};
                css_pkg::REG_IRQ_EN: rdata_reg <= {28'h0, ien_reg};
                default: begin
                    rdata_reg <= 32'h0;
                    rresp_reg <= 2'b10;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ==========================================
    // Checks
    chk_shdn_stops_power: assert property (@(posedge clk) disable iff (!rst_n)
        shdn_below |=> !power_on) else $error("power on during shutdown");
    chk_shdn_fault_shown: assert property (@(posedge clk) disable iff (!rst_n)
        shdn_below |=> indication == css_pkg::CSS_IND_FAULT) else $error("no fault");
    chk_shdn_recover_rm: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == css_pkg::CSS_SHDN && !shdn_below && !rx_present
        |=> state_reg == css_pkg::CSS_IDLE) else $error("no recovery on removal");
    chk_start_cues: assert property (@(posedge clk) disable iff (!rst_n)
        go_xfer |=> start_out [*2]) else $error("start pulse missing");
    chk_cue_new_only: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(start_out) |-> $past(go_xfer)) else $error("burst without transfer");
    chk_ept_halt: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == css_pkg::CSS_XFER && ept_done && !shdn_below
        |=> state_reg == css_pkg::CSS_HOLD && indication == css_pkg::CSS_IND_DONE)
        else $error("ept not handled");
    chk_trickle_power: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == css_pkg::CSS_XFER && cs_full && !ept_done && !shdn_below && rx_present
        |=> power_on && indication == css_pkg::CSS_IND_DONE) else $error("trickle");
    chk_low_resume: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == css_pkg::CSS_XFER && cs_low && !shdn_below
        |=> indication == css_pkg::CSS_IND_CHG) else $error("no charging resume");
    chk_sleep_wake: assert property (@(posedge clk) disable iff (!rst_n)
        sleep_cmd |-> state_reg == css_pkg::CSS_SLEEP) else $error("sleep bad");
    chk_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
        go_xfer |=> ists_reg[css_pkg::IRQ_START]) else $error("start event not latched");
    cov_start: cover property (@(posedge clk) disable iff (!rst_n) go_xfer);
    cov_ept: cover property (@(posedge clk) disable iff (!rst_n) state_reg == css_pkg::CSS_HOLD);
    cov_shdn: cover property (@(posedge clk) disable iff (!rst_n) $rose(shdn_below));
    cov_sleep: cover property (@(posedge clk) disable iff (!rst_n) sleep_cmd);
endmodule // css_supervisor

// ===== shared/css_pkg.sv
// Purpose: constants and types shared by the charge session supervisor
// Assumes: 125 MHz system clock
// Notes: AXI4-Lite register map, timing constants, states
package css_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    // Times in their own units
    localparam int unsigned TONE_MS = 400;
    localparam int unsigned TONE_HZ = 4000;
    localparam int unsigned EPT_HOLD_S = 5;
    localparam int unsigned SHDN_MIN = 5;
    localparam int unsigned WAKE_MS = 400;
    // Derived cycle counts
    localparam longint unsigned MS_CYC = CLK_HZ / 1000;
    localparam longint unsigned TONE_CYC = MS_CYC * TONE_MS;
    localparam longint unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
    localparam longint unsigned EPT_CYC = longint'(CLK_HZ) * EPT_HOLD_S;
    localparam longint unsigned SHDN_CYC = longint'(CLK_HZ) * 60 * SHDN_MIN;
    localparam longint unsigned WAKE_CYC = MS_CYC * WAKE_MS;
    // Charge status thresholds, percent
    localparam logic [7:0] CS_FULL = 8'h64;
    localparam logic [7:0] CS_LOW = 8'h5a;
    localparam logic [7:0] EPT_CODE_DONE = 8'h01;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_EN = 8'h0c;
    localparam logic [7:0] REG_IRQ_CLR = 8'h10;
    localparam logic [7:0] REG_PKT = 8'h14;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    // Interrupt bit positions
    localparam int unsigned IRQ_SHDN = 0;
    localparam int unsigned IRQ_START = 1;
    localparam int unsigned IRQ_DONE = 2;
    localparam int unsigned IRQ_FULL = 3;
    localparam int unsigned IRQ_W = 4;
    // Packet kinds written to REG_PKT bits 9:8
    localparam logic [1:0] PKT_EPT = 2'h1;
    localparam logic [1:0] PKT_CS = 2'h2;

    typedef enum logic [2:0] {
        CSS_IDLE = 3'b000,
        CSS_XFER = 3'b001,
        CSS_HOLD = 3'b010,
        CSS_SHDN = 3'b011,
        CSS_SLEEP = 3'b100
    } css_state_t;

    typedef enum logic [1:0] {
        CSS_IND_OFF = 2'b00,
        CSS_IND_CHG = 2'b01,
        CSS_IND_DONE = 2'b10,
        CSS_IND_FAULT = 2'b11
    } css_ind_t;
endpackage

// ===== shared/css_cue_if.sv
// Purpose: carries start cue request and outputs between modules
// Assumes: one clock
// Notes: start is a one-cycle pulse
`timescale 1ns/1ps
interface css_cue_if;
    logic start;
    logic tone;
    logic pulse;
    logic busy;
    modport ctl (output start, input tone, input pulse, input busy);
    modport gen (input start, output tone, output pulse, output busy);
endinterface

// ===== rtl/css_cue_gen.sv
// Purpose: tone burst and start pulse generator
// Assumes: start is a one-cycle pulse on a new transfer
// Notes: outputs low outside the burst
`timescale 1ns/1ps
module css_cue_gen #(
    parameter longint unsigned BURST_CYC = css_pkg::TONE_CYC,
    parameter longint unsigned HALF_CYC = css_pkg::TONE_HALF_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    css_cue_if.gen cue
);
    logic [31:0] len_reg;
    logic [31:0] half_reg;
    logic tone_reg;
    logic act_reg;

    // ==========================================
    // Burst length and square wave
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            len_reg <= 32'h0;
            half_reg <= 32'h0;
            tone_reg <= 1'b0;
            act_reg <= 1'b0;
        end else if (cue.start) begin
            len_reg <= 32'(BURST_CYC - 1);
            half_reg <= 32'(HALF_CYC - 1);
            tone_reg <= 1'b1;
            act_reg <= 1'b1;
        end else if (act_reg) begin
            if (len_reg == 32'h0) begin
                act_reg <= 1'b0;
                tone_reg <= 1'b0;
            end else begin
                len_reg <= len_reg - 32'h1;
                if (half_reg == 32'h0) begin
                    half_reg <= 32'(HALF_CYC - 1);
                    tone_reg <= ~tone_reg;
                end else begin
                    half_reg <= half_reg - 32'h1;
                end
            end
        end
    end

    assign cue.tone = tone_reg;
    assign cue.pulse = act_reg;
    assign cue.busy = act_reg;

    chk_tone_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        !act_reg |-> !tone_reg) else $error("tone high outside burst");
endmodule // css_cue_gen

// ===== tb/css_sup_model.sv
// Purpose: low-power supervisor companion seen from the device pins
// Assumes: sleep_cmd is a one-cycle pulse
// Notes: hold is short so the wake ping stays within the detection limit
`timescale 1ns/1ps
module css_sup_model #(
    parameter int HOLD_CYC = 30
) (
    input wire logic clk,
    input wire logic sleep_cmd,
    input wire logic [1:0] indication,
    output logic sup_rst_n,
    output logic [1:0] led_keep
);
    int cnt;
    initial begin
        cnt = 0;
        sup_rst_n = 1'b1;
        led_keep = 2'h0;
    end
    // Timed reset hold after a sleep command; timer, not an edge, ends it
    always @(posedge clk) begin
        if (sleep_cmd === 1'b1 && cnt == 0) begin
            cnt <= HOLD_CYC;
            sup_rst_n <= 1'b0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            sup_rst_n <= 1'b1;
        end
    end
    // LED state frozen while the device sits in reset
    always @(posedge clk) begin
        if (sup_rst_n === 1'b1 && sleep_cmd !== 1'b1) begin
            led_keep <= indication;
        end
    end
endmodule // css_sup_model

// ===== tb/test_css_supervisor.sv
// Purpose: self-checking bench for the charge session supervisor
// Assumes: shortened counts; supervisor model owns part of the reset line
// Notes: register reads are noted in a queue and checked by a monitor
`timescale 1ns/1ps
`define CHK(g, w) begin samples_checked++; if ((g) !== (w)) begin mismatches++; \
    $display("BAD %0t got %0h want %0h", $time, g, w); end end
module test_css_supervisor;
    localparam longint unsigned SHDN_N = 200;
    localparam longint unsigned EPT_N = 50;
    localparam longint unsigned BURST_N = 100;
    // Burst holds a whole number of tone periods, so the tone is high half of it
    localparam longint unsigned HALF_N = 10;
    logic clk, bench_rst_n, por_done, shdn_below, rx_present, sup_strap, pkt_valid;
    logic power_on, tone_out, start_out, sleep_cmd, fw_load, irq, sup_rst_n;
    logic [1:0] pkt_kind, indication, led_keep, s_axi_bresp, s_axi_rresp;
    logic [7:0] pkt_value, s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [33:0] rd_q[$];
    logic [33:0] rd_exp;
    int mismatches, samples_checked, n, t;
    // Bench reset and the supervisor's reset pull share the pin
    wire logic rst_n = bench_rst_n & sup_rst_n;
    initial clk = 1'b0;
    always #4 clk = ~clk;
    css_supervisor #(.SHDN_CYC(SHDN_N), .EPT_CYC(EPT_N), .WAKE_CYC(40), .BURST_CYC(BURST_N),
        .HALF_CYC(HALF_N))
    css_supervisor_i (.clk, .rst_n, .por_done, .shdn_below, .rx_present, .sup_strap,
        .pkt_valid, .pkt_kind, .pkt_value, .power_on, .tone_out, .start_out, .indication,
        .sleep_cmd, .fw_load, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    css_sup_model #(.HOLD_CYC(30)) css_sup_model_i (.clk, .sleep_cmd, .indication,
        .sup_rst_n, .led_keep);
    // ==========================================================
    // Bus and stimulus helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (s_axi_awready === 1'b1 && s_axi_awvalid === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1 && s_axi_wvalid === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && k < 200);
        s_axi_bready <= 1'b0;
        `CHK({s_axi_bvalid, s_axi_bresp}, 3'b100)
    endtask
    // Read note goes on the queue before the request is raised
    task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
        int k;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rd_q.push_back(e);
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (s_axi_arready === 1'b1 && s_axi_arvalid === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && k < 200);
        s_axi_rready <= 1'b0;
    endtask
    task automatic pkt(input logic [1:0] k, input logic [7:0] v);
        pkt_kind <= k;
        pkt_value <= v;
        pkt_valid <= 1'b1;
        @(posedge clk);
        pkt_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic report_and_stop();
        mismatches += rd_q.size(); // Reads never answered
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Monitor pairs each read answer with the oldest note
    always @(posedge clk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            rd_exp = (rd_q.size() > 0) ? rd_q.pop_front() : 34'h3ffffffff;
            `CHK({s_axi_rresp, s_axi_rdata}, rd_exp)
        end
    end
    // Watchdog; whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("BAD %0t watchdog expired", $time);
        report_and_stop();
    end
    // ==========================================================
    // Main sequence
    initial begin
        {bench_rst_n, por_done, shdn_below, rx_present, pkt_valid, pkt_kind} = 7'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {pkt_value, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 28'h0;
        s_axi_wdata = 32'h0;
        sup_strap = 1'b1;
        mismatches = 0;
        samples_checked = 0;
        seed = 32'h000105c0;
        repeat (4) @(posedge clk);
        `CHK({power_on, start_out, tone_out, fw_load, s_axi_awready}, 5'h01)
        bench_rst_n <= 1'b1;
        rx_present <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK(power_on, 1'b0)
        por_done <= 1'b1;
        for (n = 0; n < 20 && fw_load !== 1'b1; n++) @(posedge clk);
        `CHK(fw_load, 1'b1)
        for (n = 0; n < 20 && start_out !== 1'b1; n++) @(posedge clk);
        n = 0;
        t = 0;
        while (start_out === 1'b1 && n < 1000) begin
            t += (tone_out === 1'b1);
            n++;
            @(posedge clk);
        end
        `CHK(n, int'(BURST_N))
        `CHK(t, int'(BURST_N / 2))
        t = 0;
        repeat (30) begin
            @(posedge clk);
            t += (start_out !== 1'b0 || tone_out !== 1'b0);
        end
        `CHK({t, power_on, indication}, {32'h0, 1'b1, css_pkg::CSS_IND_CHG})
        $display("test start cues finished");
        // Sticky status, masking and clearing of the interrupt
        axi_rd(css_pkg::REG_IRQ_STAT, 34'h2);
        `CHK(irq, 1'b0)
        seed = lfsr(seed);
        axi_wr(css_pkg::REG_IRQ_EN, {28'h0, seed[3:0] | 4'h2});
        `CHK(irq, 1'b1)
        axi_wr(css_pkg::REG_IRQ_EN, 32'h1);
        `CHK(irq, 1'b0)
        axi_wr(css_pkg::REG_IRQ_EN, 32'hf);
        axi_wr(css_pkg::REG_IRQ_CLR, 32'hf);
        `CHK(irq, 1'b0)
        axi_rd(8'h18, {2'b10, 32'h0});
        $display("test registers finished");
        pkt(css_pkg::PKT_CS, css_pkg::CS_FULL);
        `CHK({power_on, indication}, {1'b1, css_pkg::CSS_IND_DONE})
        pkt(css_pkg::PKT_CS, 8'h5f);
        `CHK(indication, css_pkg::CSS_IND_DONE)
        seed = lfsr(seed);
        pkt(css_pkg::PKT_CS, 8'(seed % 90));
        `CHK({power_on, indication}, {1'b1, css_pkg::CSS_IND_CHG})
        axi_wr(css_pkg::REG_PKT, {22'h0, css_pkg::PKT_EPT, css_pkg::EPT_CODE_DONE});
        `CHK({power_on, indication}, {1'b0, css_pkg::CSS_IND_DONE})
        repeat (int'(EPT_N) - 10) @(posedge clk);
        `CHK(power_on, 1'b0)
        for (n = 0; n < 40 && start_out !== 1'b1; n++) @(posedge clk);
        `CHK({power_on, start_out}, 2'h3)
        $display("test charge status finished");
        shdn_below <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK({power_on, indication, irq}, {1'b0, css_pkg::CSS_IND_FAULT, 1'b1})
        shdn_below <= 1'b0;
        repeat (int'(SHDN_N) - 50) @(posedge clk);
        `CHK(power_on, 1'b0)
        for (n = 0; n < 100 && power_on !== 1'b1; n++) @(posedge clk);
        `CHK(power_on, 1'b1)
        shdn_below <= 1'b1;
        repeat (3) @(posedge clk);
        shdn_below <= 1'b0;
        rx_present <= 1'b0;
        repeat (5) @(posedge clk);
        rx_present <= 1'b1;
        for (n = 0; n < 30 && power_on !== 1'b1; n++) @(posedge clk);
        `CHK(power_on, 1'b1)
        $display("test shutdown finished");
        rx_present <= 1'b0;
        axi_wr(css_pkg::REG_PKT, {22'h0, css_pkg::PKT_EPT, css_pkg::EPT_CODE_DONE});
        repeat (int'(EPT_N) + 10) @(posedge clk);
        axi_wr(css_pkg::REG_CTRL, 32'h1);
        for (n = 0; n < 50 && sleep_cmd !== 1'b1; n++) @(posedge clk);
        `CHK(sleep_cmd, 1'b1)
        repeat (3) @(posedge clk);
        `CHK({sup_rst_n, power_on, indication, led_keep}, 6'h0)
        rx_present <= 1'b1;
        for (n = 0; n < 80 && power_on !== 1'b1; n++) @(posedge clk);
        `CHK(power_on, 1'b1)
        $display("test standby finished");
        report_and_stop();
    end
endmodule // test_css_supervisor
